//--- src/u_test_defines.vh
// Constants for the U-interface test control register bank
`ifndef U_TEST_DEFINES_VH
`define U_TEST_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_LINE_CONTROL_A 8'h07
`define IDX_LINE_CONTROL_B 8'h08
`define ADDR_LINE_CONTROL_A 10'h01c
`define ADDR_LINE_CONTROL_B 10'h020
`define ADDR_WIDTH 10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_STARTUP_REQUEST 0
`define BIT_TX_RESERVED_A 7
`define BIT_TX_RESERVED_B 6
`define BIT_TX_R16 5
`define BIT_TX_R15 4
`define BIT_LOOPBACK_POINT 3
`define BIT_LOCAL_LOOPBACK 2
`define BIT_PULSE_MAGNITUDE 1
`define BIT_SINGLE_PULSE 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RESET_LINE_CONTROL_A 7'h00
`define RESET_LINE_CONTROL_B 8'hf0

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 20
`define PULSE_PERIOD_NS 125000
// 125 us at a 20 ns clock, sized to the period counter
`define PULSE_PERIOD_CYCLES 13'd6250
`define PULSE_COUNT_WIDTH 13

// ----------------------------------------
// 2B1Q symbol codes: {sign, inner}
// ----------------------------------------
`define SYM_PLUS3 2'b10
`define SYM_PLUS1 2'b11
`define SYM_MINUS1 2'b01
`define SYM_MINUS3 2'b00

`endif

//--- src/single_pulse_gen.v
// Single 2B1Q test pulse generator, one pulse per frame period
`timescale 1ns/100ps
`include "u_test_defines.vh"

module single_pulse_gen #(
  parameter [`PULSE_COUNT_WIDTH-1:0] PERIOD_CYCLES = `PULSE_PERIOD_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire enable,
  input wire magnitude_one,
  output reg pulse_strobe,
  output reg [1:0] pulse_symbol
);

  reg [`PULSE_COUNT_WIDTH-1:0] count;
  reg positive;

  always @(posedge sys_clk) begin
    if (rst || !enable) begin
      count <= {`PULSE_COUNT_WIDTH{1'b0}};
      positive <= 1'b1;
      pulse_strobe <= 1'b0;
      pulse_symbol <= `SYM_PLUS3;
    end else begin
      pulse_strobe <= 1'b0;
      if (count == {`PULSE_COUNT_WIDTH{1'b0}}) begin
        // One pulse then silence until the next period
        count <= PERIOD_CYCLES - 1'b1;
        pulse_strobe <= 1'b1;
        // Magnitude from the select bit
        if (magnitude_one) begin
          pulse_symbol <= positive ? `SYM_PLUS1 : `SYM_MINUS1;
        end else begin
          pulse_symbol <= positive ? `SYM_PLUS3 : `SYM_MINUS3;
        end
        positive <= ~positive;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // single_pulse_gen

//--- src/u_interface_test_control.v
// Register bank for U-interface start-up, overhead, loopback and pulse test control
`timescale 1ns/100ps
`include "u_test_defines.vh"

// Function
// - Writing one to startup request starts one activation attempt; zero does nothing.
// - After the attempt is made, hardware clears the startup request bit itself.
// - Control B bits 7..4 drive upstream overhead bits R64, R25, R16, R15.
// - Loopback point select zero loops at the U block line interface.
// - Loopback point select one loops at digital/analog boundary; line may stay.
// - Local loopback bit 2 loops data at selected point; zero is normal.
// - During loopback, echo canceller off and receive scrambler matches transmit.
// - Pulse magnitude zero sends plus/minus three, one sends plus/minus one.
// - Single pulse enable sends isolated 2B1Q pulses every 125 microseconds.
// - Successive test pulses alternate positive and negative polarity.
module u_interface_test_control #(
  parameter [`PULSE_COUNT_WIDTH-1:0] PULSE_PERIOD = `PULSE_PERIOD_CYCLES
) (
  input wire sys_clk,
  input wire rst,
  input wire [`ADDR_WIDTH-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  input wire startup_attempt_done,
  output reg startup_request,
  output wire [6:0] line_control_a_other,
  output wire tx_reserved_a,
  output wire tx_reserved_b,
  output wire tx_reserved_r16,
  output wire tx_reserved_r15,
  output wire loop_at_line,
  output wire loop_at_converter,
  output wire echo_canceller_off,
  output wire rx_scrambler_as_tx,
  output wire test_pulse_strobe,
  output wire [1:0] test_pulse_symbol
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function [1:0] decode_addr;
    input [`ADDR_WIDTH-1:0] addr;
    begin
      if (addr == `ADDR_LINE_CONTROL_A) begin
        decode_addr = 2'h1;
      end else if (addr == `ADDR_LINE_CONTROL_B) begin
        decode_addr = 2'h2;
      end else begin
        decode_addr = 2'h0;
      end
    end
  endfunction

  reg [6:0] control_a_rest;
  reg [7:0] control_b;
  reg answered;
  reg done_meta;
  reg done_sync;
  reg done_prev;
  wire [1:0] sel;
  wire access;
  wire done_rise;

  assign sel = decode_addr(avs_address);
  assign access = (avs_read || avs_write) && !answered;
  // One wait cycle: answer lands on the second edge of each request
  assign avs_waitrequest = (avs_read || avs_write) && !answered;
  assign done_rise = done_sync && !done_prev;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      answered <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_response <= 2'b00;
    end else begin
      answered <= access;
      if (access && avs_read) begin
        avs_response <= (sel == 2'h0) ? 2'b11 : 2'b00;
        if (sel == 2'h1) begin
          avs_readdata <= {24'h000000, control_a_rest, startup_request};
        end else if (sel == 2'h2) begin
          avs_readdata <= {24'h000000, control_b};
        end else begin
          avs_readdata <= 32'h00000000;
        end
      end else if (access && avs_write) begin
        avs_response <= (sel == 2'h0) ? 2'b11 : 2'b00;
      end
    end
  end

  // Attempt completion comes from the transceiver, resynchronised
  always @(posedge sys_clk) begin
    if (rst) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= startup_attempt_done;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      control_a_rest <= `RESET_LINE_CONTROL_A;
      startup_request <= 1'b0;
      control_b <= `RESET_LINE_CONTROL_B;
    end else begin
      // A fresh write of one wins over the hardware clear
      if (access && avs_write && sel == 2'h1 && avs_byteenable[0]) begin
        control_a_rest <= avs_writedata[7:1];
        if (avs_writedata[`BIT_STARTUP_REQUEST]) begin
          startup_request <= 1'b1;
        end else if (done_rise) begin
          startup_request <= 1'b0;
        end
      end else if (done_rise) begin
        startup_request <= 1'b0;
      end
      if (access && avs_write && sel == 2'h2 && avs_byteenable[0]) begin
        control_b <= avs_writedata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Transceiver controls
  // ----------------------------------------
  assign line_control_a_other = control_a_rest;
  assign tx_reserved_a = control_b[`BIT_TX_RESERVED_A];
  assign tx_reserved_b = control_b[`BIT_TX_RESERVED_B];
  assign tx_reserved_r16 = control_b[`BIT_TX_R16];
  assign tx_reserved_r15 = control_b[`BIT_TX_R15];
  // Line-point loop relies on software having opened the line
  assign loop_at_line = control_b[`BIT_LOCAL_LOOPBACK] &&
    !control_b[`BIT_LOOPBACK_POINT];
  assign loop_at_converter = control_b[`BIT_LOCAL_LOOPBACK] &&
    control_b[`BIT_LOOPBACK_POINT];
  assign echo_canceller_off = control_b[`BIT_LOCAL_LOOPBACK];
  assign rx_scrambler_as_tx = control_b[`BIT_LOCAL_LOOPBACK];

  single_pulse_gen #(
    .PERIOD_CYCLES(PULSE_PERIOD)
  ) u_pulse (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(control_b[`BIT_SINGLE_PULSE]),
    .magnitude_one(control_b[`BIT_PULSE_MAGNITUDE]),
    .pulse_strobe(test_pulse_strobe),
    .pulse_symbol(test_pulse_symbol)
  );

endmodule // u_interface_test_control

//--- tb/u_test_checker_asserts.sv
// Assertion checker for the U-interface test control bank
`timescale 1ns/100ps
module u_test_checker (
  input wire sys_clk, rst, avs_read, avs_write, avs_waitrequest,
  input wire [9:0] avs_address,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [1:0] avs_response, test_pulse_symbol,
  input wire startup_attempt_done, startup_request, tx_reserved_a, tx_reserved_b,
  input wire tx_reserved_r16, tx_reserved_r15, loop_at_line, loop_at_converter,
  input wire echo_canceller_off, rx_scrambler_as_tx, test_pulse_strobe
);
  reg [7:0] ctl_b;
  wire take = avs_write && avs_waitrequest && avs_byteenable[0];
  always @(posedge sys_clk)
    if (rst) ctl_b <= 8'hf0;
    else if (take && avs_address == 10'h020) ctl_b <= avs_writedata[7:0];
  // Cycles since the last strobe; seen marks a strobe since enable rose
  // Cleared while disabled, so a quick re-enable is not taken as a double pulse
  reg [3:0] since;
  reg seen;
  always @(posedge sys_clk)
    if (rst || !ctl_b[0]) begin
      since <= 4'h0;
      seen <= 1'b0;
    end else begin
      seen <= seen || test_pulse_strobe;
      since <= test_pulse_strobe ? 4'h0 : since + {3'h0, since != 4'hf};
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Spacing of 8 matches the shortened pulse period used in the bench
  sequence gap_s;
    test_pulse_strobe ##1 !test_pulse_strobe [*7] ##1 test_pulse_strobe;
  endsequence
  start_set_a: assert property (
    take && avs_address == 10'h01c && avs_writedata[0] |=> startup_request)
    else $error("start not set");
  start_clr_a: assert property (
    $rose(startup_attempt_done) && !avs_write |-> ##[1:4] !startup_request)
    else $error("start not cleared");
  tx_bits_a: assert property (
    {tx_reserved_a, tx_reserved_b, tx_reserved_r16, tx_reserved_r15} == ctl_b[7:4])
    else $error("overhead bits wrong");
  loop_line_a: assert property (loop_at_line == (ctl_b[2] & ~ctl_b[3]))
    else $error("line loop wrong");
  loop_conv_a: assert property (loop_at_converter == (ctl_b[2] & ctl_b[3]))
    else $error("converter loop wrong");
  loop_cfg_a: assert property (
    echo_canceller_off == ctl_b[2] && rx_scrambler_as_tx == ctl_b[2])
    else $error("loop config wrong");
  pulse_mag_a: assert property (
    test_pulse_strobe |-> test_pulse_symbol[0] == ctl_b[1]) else $error("magnitude wrong");
  pulse_rate_a: assert property (
    seen && ctl_b[0] |-> test_pulse_strobe == (since == 4'h7))
    else $error("pulse spacing wrong");
  pulse_alt_a: assert property (
    gap_s |-> test_pulse_symbol[1] != $past(test_pulse_symbol[1], 8))
    else $error("polarity not alternating");
  bad_addr_a: assert property (avs_read && avs_waitrequest && avs_address != 10'h01c
    && avs_address != 10'h020 |=> avs_response == 2'b11) else $error("unmapped not flagged");
endmodule // u_test_checker
bind u_interface_test_control u_test_checker u_test_checker_i (.*);

//--- tb/far_end_model.sv
// Far-end transceiver model answering activation attempts
`timescale 1ns/100ps
module far_end_model #(parameter integer DELAY = 4) (
  input wire sys_clk,
  input wire startup_request,
  output reg startup_attempt_done
);
  integer cnt = 0;
  initial startup_attempt_done = 1'b0;
  // Done rises DELAY cycles into an attempt, falls once the request is gone
  always @(posedge sys_clk) begin
    cnt <= startup_request ? cnt + 1 : 0;
    startup_attempt_done <= startup_request && cnt >= DELAY;
  end
endmodule // far_end_model

//--- tb/u_interface_test_control_tb.sv
// Self-checking bench for the U-interface test control bank
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks = n_checks + 1; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module u_interface_test_control_tb;
  reg sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0;
  reg [9:0] avs_address = 0;
  reg [31:0] avs_writedata = 0;
  reg [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response, test_pulse_symbol;
  wire [6:0] line_control_a_other;
  wire avs_waitrequest, startup_attempt_done, startup_request, tx_reserved_a, tx_reserved_b;
  wire tx_reserved_r16, tx_reserved_r15, loop_at_line, loop_at_converter;
  wire echo_canceller_off, rx_scrambler_as_tx, test_pulse_strobe;
  integer error_cnt = 0, n_checks = 0, i, m, n;
  reg [31:0] q;
  reg [1:0] r;
  reg [7:0] v;
  u_interface_test_control #(.PULSE_PERIOD(13'd8)) u_interface_test_control_i (.*);
  far_end_model #(.DELAY(12)) far_end_model_i (.*);
  always #10 sys_clk = ~sys_clk;
  task close_out; begin
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input rd, input [9:0] a, input [7:0] d, input [3:0] be); begin
    @(posedge sys_clk);
    avs_read <= rd; avs_write <= !rd; avs_address <= a;
    avs_writedata <= {24'h0, d}; avs_byteenable <= be;
    @(posedge sys_clk);
    while (avs_waitrequest) @(posedge sys_clk);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 0;
    avs_write <= 0;
  end endtask
  task t_reset; begin
    bus(1, 10'h01c, 0, 4'hf); `CHK(q, 32'h0)
    `CHK(r, 2'b00)
    bus(1, 10'h020, 0, 4'hf); `CHK(q, 32'hf0)
    `CHK({tx_reserved_a, tx_reserved_b, tx_reserved_r16, tx_reserved_r15}, 4'hf)
    $display("reset values done");
  end endtask
  task t_bad; begin
    bus(0, 10'h020, 8'h00, 4'h0);
    bus(0, 10'h3fc, 8'h00, 4'hf); `CHK(r, 2'b11)
    bus(1, 10'h020, 0, 4'hf); `CHK(q, 32'hf0)
    bus(1, 10'h3fc, 0, 4'hf); `CHK(r, 2'b11) `CHK(q, 32'h0)
    $display("refusals done");
  end endtask
  task t_start; begin
    bus(0, 10'h01c, 8'h5b, 4'hf); `CHK(startup_request, 1'b1)
    `CHK(line_control_a_other, 7'h2d)
    bus(0, 10'h01c, 8'h00, 4'hf); `CHK(startup_request, 1'b1)
    `CHK(line_control_a_other, 7'h00)
    repeat (30) @(posedge sys_clk);
    bus(1, 10'h01c, 0, 4'hf); `CHK(q, 32'h0)
    $display("startup done");
  end endtask
  // Point 0 is written before its loop, standing for a disconnected line
  task t_loop; begin
    for (i = 0; i < 4; i++) begin
      v = 8'h34 * i + 8'h08;
      bus(0, 10'h020, v, 4'hf); bus(1, 10'h020, 0, 4'hf); `CHK(q[7:0], v)
      `CHK({tx_reserved_a, tx_reserved_b, tx_reserved_r16, tx_reserved_r15}, v[7:4])
      `CHK(loop_at_line, v[2] & ~v[3])
      `CHK(loop_at_converter, v[2] & v[3])
      `CHK({echo_canceller_off, rx_scrambler_as_tx}, {2{v[2]}})
    end
    $display("loopback done");
  end endtask
  task t_pulse; begin
    for (m = 0; m < 2; m++) begin
      bus(0, 10'h020, 8'hf1 | (m << 1), 4'hf);
      for (i = 0; i < 4; i++) begin
        n = 0;
        do begin @(negedge sys_clk); n++; end while (!test_pulse_strobe && n < 20);
        `CHK(test_pulse_symbol, {~i[0], m[0]})
        if (i > 0) `CHK(n, 8)
      end
      bus(0, 10'h020, 8'hf0, 4'hf);
    end
    $display("single pulse done");
  end endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    t_reset; t_bad; t_start; t_loop; t_pulse;
    close_out;
  end
  initial begin
    #60000;
    error_cnt++;
    close_out;
  end
endmodule // u_interface_test_control_tb
